// *** main_pll_clock_pkg.sv ***
// Constants and settings shared by the main PLL clock generator files
//
// Operation
// - PLL reference comes from oscillator pin, single-ended or crystal.
// - Reference multiplied by integer plus fractional factor fields.
// - Raw PLL output is halved before reaching the bypass mux.
// - Integer factor zero selects reference clock, otherwise halved PLL.
// - Mux output divided by system divider select gives system clock.
// - Integer factor is seven bits; zero bypasses, n multiplies by n.
// - Pinless internal oscillator yields fixed 10 MHz and 32 kHz.
// - Internal clocks are routed out to low-power mode logic.
// - Internal fast clock drives the missing-clock detector.
// - Auxiliary clock pin feeds only USB PLL and CAN, never main path.
// - System PLL clock, clock fail and the crystal drive pin derive from the main oscillator input.
// - Missing reference substitutes fast clock and raises clock fail.
package main_pll_clock_pkg;

  // ----------------------------------------------------------------
  // Clock rates
  // ----------------------------------------------------------------
  localparam int SYS_CLK_KHZ = 125000;
  localparam int FAST_CLK_KHZ = 10000;
  localparam int SLOW_CLK_KHZ = 32;
  localparam int TONE_ACC_W = 17;
  // Two edges per output period
  localparam int FAST_STEP = 2 * FAST_CLK_KHZ;
  localparam int SLOW_STEP = 2 * SLOW_CLK_KHZ;

  // ----------------------------------------------------------------
  // Multiplier and divider fields
  // ----------------------------------------------------------------
  localparam int MULT_INT_W = 7;
  localparam int MULT_FRAC_W = 2;
  localparam int QUARTER_W = MULT_INT_W + MULT_FRAC_W;
  localparam int CREDIT_W = 12;
  localparam int DIV_SEL_W = 6;
  localparam logic [MULT_INT_W-1:0] BYPASS_CODE = 7'h00;
  localparam logic [CREDIT_W-1:0] CREDIT_UNIT = 12'h004;
  localparam logic [MULT_FRAC_W-1:0] FRAC_RESET = 2'h0;
  localparam logic [DIV_SEL_W-1:0] DIV_RESET = 6'h00;

  // ----------------------------------------------------------------
  // Missing-clock timeout
  // ----------------------------------------------------------------
  localparam int MISS_W = 8;
  localparam int MISS_TIME_NS = 10000;
  localparam int FAST_EDGE_NS = 1000000 / (2 * FAST_CLK_KHZ);
  localparam int MISS_TICKS = MISS_TIME_NS / FAST_EDGE_NS;
  localparam logic [MISS_W-1:0] MISS_LIMIT = MISS_W'(MISS_TICKS);

endpackage

// *** fixed_tone_gen.sv ***
// Fixed-frequency square wave from a phase accumulator on the system clock
`timescale 1ns/1ns
module fixed_tone_gen
  import main_pll_clock_pkg::*;
#(
  parameter int STEP = FAST_STEP,
  parameter int MODULUS = SYS_CLK_KHZ
) (
  input wire logic sys_clk,
  input wire logic rst,
  output logic tone
);

  localparam logic [TONE_ACC_W-1:0] STEP_V = TONE_ACC_W'(STEP);
  localparam logic [TONE_ACC_W-1:0] MOD_V = TONE_ACC_W'(MODULUS);

  logic [TONE_ACC_W-1:0] phase_q;
  logic [TONE_ACC_W-1:0] phase_d;
  logic tone_q;
  logic tone_d;
  logic [TONE_ACC_W:0] phaseSum;

  // Accumulate, wrap at modulus and toggle on each wrap
  always_comb begin
    phaseSum = {1'b0, phase_q} + {1'b0, STEP_V};
    if (phaseSum >= {1'b0, MOD_V}) begin
      phase_d = TONE_ACC_W'(phaseSum - {1'b0, MOD_V});
      tone_d = ~tone_q;
    end else begin
      phase_d = phaseSum[TONE_ACC_W-1:0];
      tone_d = tone_q;
    end
  end

  // State registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_q <= '0;
      tone_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      tone_q <= tone_d;
    end
  end

  assign tone = tone_q;

endmodule

// *** main_pll_clock_generator.sv ***
// Main PLL clock path, internal oscillator clocks and missing-clock detect
`timescale 1ns/1ns
module main_pll_clock_generator
  import main_pll_clock_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic oscInPin,
  input wire logic crystalMode,
  input wire logic auxiliaryClockInput,
  input wire logic [MULT_INT_W-1:0] pllIntegerFactor,
  input wire logic [MULT_FRAC_W-1:0] pllFractionFactor,
  input wire logic [DIV_SEL_W-1:0] systemDividerSelect,
  output logic oscOutPin,
  output logic oscOutPinOe_n,
  output logic systemPllClock,
  output logic clockFailIndication,
  output logic internalFastClock,
  output logic internalSlowClock,
  output logic usbCanReferenceClock
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // Zero integer factor means the PLL is bypassed
  function automatic logic isBypass(input logic [MULT_INT_W-1:0] mult);
    isBypass = (mult == BYPASS_CODE);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic refMeta_q;
  logic refSync_q;
  logic refLast_q;
  logic auxMeta_q;
  logic auxSync_q;
  logic usbCan_q;
  logic oscOut_q;
  logic oscOe_n_q;
  logic refLast_d;
  logic usbCan_d;
  logic oscOut_d;
  logic oscOe_n_d;
  logic refEdge;

  logic fastTone;
  logic slowTone;
  logic fastLast_q;
  logic fastEdge;

  logic [MULT_INT_W-1:0] multLatch_q;
  logic [MULT_INT_W-1:0] multLatch_d;
  logic [MULT_FRAC_W-1:0] fracLatch_q;
  logic [MULT_FRAC_W-1:0] fracLatch_d;
  logic [DIV_SEL_W-1:0] divLatch_q;
  logic [DIV_SEL_W-1:0] divLatch_d;
  logic bypass;
  logic [QUARTER_W-1:0] mulQuarters;

  logic [CREDIT_W-1:0] creditAcc_q;
  logic [CREDIT_W-1:0] creditAcc_d;
  logic [CREDIT_W-1:0] creditExpect;
  logic [CREDIT_W:0] creditSum;
  logic rawTick;
  logic halfPhase_q;
  logic halfPhase_d;
  logic halfTick;
  logic muxEdge;

  logic [DIV_SEL_W-1:0] divCount_q;
  logic [DIV_SEL_W-1:0] divCount_d;
  logic divWrap;
  logic sysPll_q;
  logic sysPll_d;

  logic [MISS_W-1:0] missCount_q;
  logic [MISS_W-1:0] missCount_d;
  logic clockFail_q;
  logic clockFail_d;

  // ----------------------------------------------------------------
  // Pin synchronisers and oscillator pad
  // ----------------------------------------------------------------

  // Reference edge after two flops; crystal drive and aux pass-through
  always_comb begin
    refLast_d = refSync_q;
    refEdge = refSync_q ^ refLast_q;
    // Crystal amplifier drives the second pin inverted
    oscOut_d = ~refSync_q;
    oscOe_n_d = ~crystalMode;
    // Aux pin goes only to the USB and CAN reference
    usbCan_d = auxSync_q;
  end

  // Synchroniser and pad registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      refMeta_q <= 1'b0;
      refSync_q <= 1'b0;
      refLast_q <= 1'b0;
      auxMeta_q <= 1'b0;
      auxSync_q <= 1'b0;
      usbCan_q <= 1'b0;
      oscOut_q <= 1'b0;
      oscOe_n_q <= 1'b1;
    end else begin
      refMeta_q <= oscInPin;
      refSync_q <= refMeta_q;
      refLast_q <= refLast_d;
      auxMeta_q <= auxiliaryClockInput;
      auxSync_q <= auxMeta_q;
      usbCan_q <= usbCan_d;
      oscOut_q <= oscOut_d;
      oscOe_n_q <= oscOe_n_d;
    end
  end

  // ----------------------------------------------------------------
  // Internal oscillator clocks
  // ----------------------------------------------------------------

  // Fixed 10 MHz tone, not configurable
  fixed_tone_gen #(
    .STEP(FAST_STEP),
    .MODULUS(SYS_CLK_KHZ)
  ) fastGen (
    .sys_clk(sys_clk),
    .rst(rst),
    .tone(fastTone)
  );

  // Fixed 32 kHz tone, not configurable
  fixed_tone_gen #(
    .STEP(SLOW_STEP),
    .MODULUS(SYS_CLK_KHZ)
  ) slowGen (
    .sys_clk(sys_clk),
    .rst(rst),
    .tone(slowTone)
  );

  // Both tones go to the low-power mode logic
  assign internalFastClock = fastTone;
  assign internalSlowClock = slowTone;

  // Edge of the fast tone paces the missing-clock timer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fastLast_q <= 1'b0;
    end else begin
      fastLast_q <= fastTone;
    end
  end

  assign fastEdge = fastTone ^ fastLast_q;

  // ----------------------------------------------------------------
  // PLL multiplier model
  // ----------------------------------------------------------------

  // Each reference edge credits the multiplier in quarter steps;
  // one raw PLL edge is spent per four quarters of credit
  always_comb begin
    bypass = isBypass(multLatch_q);
    mulQuarters = {multLatch_q, fracLatch_q};
    creditExpect = creditAcc_q + CREDIT_W'(mulQuarters);
    rawTick = (creditAcc_q >= CREDIT_UNIT);
    creditSum = {1'b0, creditAcc_q};
    if (rawTick) begin
      creditSum = creditSum - {1'b0, CREDIT_UNIT};
    end
    if (refEdge && !bypass) begin
      creditSum = creditSum + (CREDIT_W+1)'(mulQuarters);
    end
    if (bypass) begin
      creditSum = '0;
    end
    // Saturate rather than wrap on a wildly high ratio
    creditAcc_d = creditSum[CREDIT_W] ? '1 : creditSum[CREDIT_W-1:0];
    // Every second raw edge passes: divide by two
    halfPhase_d = rawTick ? ~halfPhase_q : halfPhase_q;
    halfTick = rawTick && halfPhase_q;
    // Bypass mux picks reference or halved PLL edges
    muxEdge = bypass ? refEdge : halfTick;
  end

  // Multiplier state registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      creditAcc_q <= '0;
      halfPhase_q <= 1'b0;
    end else begin
      creditAcc_q <= creditAcc_d;
      halfPhase_q <= halfPhase_d;
    end
  end

  // ----------------------------------------------------------------
  // Output divider and settings latch
  // ----------------------------------------------------------------

  // Toggle every (select + 1) mux edges; new settings are only taken
  // at a toggle so no runt pulse can appear on the output
  always_comb begin
    divWrap = muxEdge && (divCount_q == divLatch_q);
    divCount_d = divCount_q;
    multLatch_d = multLatch_q;
    fracLatch_d = fracLatch_q;
    divLatch_d = divLatch_q;
    sysPll_d = sysPll_q;
    if (divWrap) begin
      divCount_d = '0;
      multLatch_d = pllIntegerFactor;
      fracLatch_d = pllFractionFactor;
      divLatch_d = systemDividerSelect;
      sysPll_d = ~sysPll_q;
    end else if (muxEdge) begin
      divCount_d = divCount_q + 1'b1;
    end
    // Fail substitutes the internal fast clock
    if (clockFail_q) begin
      sysPll_d = fastTone;
    end
  end

  // Divider registers; reset starts in bypass with divide-by-one
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      divCount_q <= '0;
      multLatch_q <= BYPASS_CODE;
      fracLatch_q <= FRAC_RESET;
      divLatch_q <= DIV_RESET;
      sysPll_q <= 1'b0;
    end else begin
      divCount_q <= divCount_d;
      multLatch_q <= multLatch_d;
      fracLatch_q <= fracLatch_d;
      divLatch_q <= divLatch_d;
      sysPll_q <= sysPll_d;
    end
  end

  // ----------------------------------------------------------------
  // Missing-clock detection
  // ----------------------------------------------------------------

  // Count fast edges since the last reference edge; fail is sticky
  always_comb begin
    missCount_d = missCount_q;
    if (refEdge) begin
      missCount_d = '0;
    end else if (fastEdge && (missCount_q != MISS_LIMIT)) begin
      missCount_d = missCount_q + 1'b1;
    end
    clockFail_d = clockFail_q || (missCount_q == MISS_LIMIT);
  end

  // Detector registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      missCount_q <= '0;
      clockFail_q <= 1'b0;
    end else begin
      missCount_q <= missCount_d;
      clockFail_q <= clockFail_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // System clock is the divided bypass mux output until clock fail substitutes the fast clock
  assign systemPllClock = sysPll_q;
  assign clockFailIndication = clockFail_q;
  assign usbCanReferenceClock = usbCan_q;
  assign oscOutPin = oscOut_q;
  assign oscOutPinOe_n = oscOe_n_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  chk_credit_add: assert property (
    @(posedge sys_clk) disable iff (rst)
    (refEdge && !isBypass(multLatch_q) && (creditAcc_q < CREDIT_UNIT))
      |=> (creditAcc_q == $past(creditExpect)))
    else $error("credit not increased by multiplier");

  chk_half_rate: assert property (
    @(posedge sys_clk) disable iff (rst)
    halfTick |=> !halfTick)
    else $error("halved edges back to back");

  chk_bypass_toggle: assert property (
    @(posedge sys_clk) disable iff (rst)
    (isBypass(multLatch_q) && refEdge && (divCount_q == divLatch_q)
      && !clockFail_q) |=> (systemPllClock != $past(systemPllClock)))
    else $error("bypass edge did not toggle output");

  chk_divider_hold: assert property (
    @(posedge sys_clk) disable iff (rst)
    (!muxEdge && !clockFail_q) |=> $stable(systemPllClock))
    else $error("output moved without a mux edge");

  chk_settings_stable: assert property (
    @(posedge sys_clk) disable iff (rst)
    !divWrap |=> ($stable(multLatch_q) && $stable(divLatch_q)
      && $stable(fracLatch_q)))
    else $error("settings changed away from a toggle");

  chk_timeout_fail: assert property (
    @(posedge sys_clk) disable iff (rst)
    (missCount_q == MISS_LIMIT) |=> clockFail_q)
    else $error("timeout did not raise clock fail");

  chk_fail_sticky: assert property (
    @(posedge sys_clk) disable iff (rst)
    clockFail_q |=> clockFail_q [*2])
    else $error("clock fail dropped");

  chk_fail_subst: assert property (
    @(posedge sys_clk) disable iff (rst)
    clockFail_q |=> (systemPllClock == $past(fastTone)))
    else $error("fast clock not substituted on fail");

endmodule

// *** osc_source_model.sv ***
// Oscillator model that drives the reference pin of the clock generator
`timescale 1ns/1ns
module osc_source_model (
  input wire logic sys_clk,
  input wire logic run,
  input wire logic [7:0] halfCycles,
  output logic oscInPin,
  output int edgeCount
);
  int cnt;

  // Toggle every halfCycles clocks while running, stand still when stopped
  initial begin
    oscInPin = 1'b0;
    edgeCount = 0;
    cnt = 0;
    forever begin
      @(negedge sys_clk);
      if (run) begin
        cnt++;
        if (cnt >= halfCycles) begin
          cnt = 0;
          oscInPin = ~oscInPin;
          edgeCount++;
        end
      end
    end
  end
endmodule

// *** main_pll_clock_generator_tb_top.sv ***
// Self-checking bench for the main PLL clock generator
`timescale 1ns/1ns
module main_pll_clock_generator_tb_top
  import main_pll_clock_pkg::*;
;
  logic sys_clk, rst, crystalMode, auxIn, run, checkAux, followFast;
  logic pllLast, fastLast, slowLast;
  logic [MULT_INT_W-1:0] intF;
  logic [MULT_FRAC_W-1:0] fracF;
  logic [DIV_SEL_W-1:0] divSel;
  logic [7:0] halfCycles;
  logic [2:0] auxHist;
  logic oscInPin, oscOutPin, oeN, pllClk, failInd, fastClk, slowClk, usbClk;
  int edges, nMismatch, samplesChecked, seed, cycles;
  int pllToggles, fastToggles, slowToggles;

  main_pll_clock_generator dut_u (.sys_clk(sys_clk), .rst(rst),
    .oscInPin(oscInPin), .crystalMode(crystalMode),
    .auxiliaryClockInput(auxIn), .pllIntegerFactor(intF),
    .pllFractionFactor(fracF), .systemDividerSelect(divSel),
    .oscOutPin(oscOutPin), .oscOutPinOe_n(oeN), .systemPllClock(pllClk),
    .clockFailIndication(failInd), .internalFastClock(fastClk),
    .internalSlowClock(slowClk), .usbCanReferenceClock(usbClk));

  osc_source_model osc_u (.sys_clk(sys_clk), .run(run),
    .halfCycles(halfCycles), .oscInPin(oscInPin), .edgeCount(edges));

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic check(input logic ok, input string msg);
    samplesChecked++;
    if (ok !== 1'b1) begin
      nMismatch++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Aux history on the sampling edge, cleared like the synchroniser
  always @(posedge sys_clk) begin
    cycles++;
    auxHist <= rst ? 3'h0 : {auxHist[1:0], auxIn};
  end

  // Toggle counting, aux and fail-follow compares, random aux drive
  always @(negedge sys_clk) begin
    if (pllClk !== pllLast) pllToggles++;
    if (fastClk !== fastLast) fastToggles++;
    if (slowClk !== slowLast) slowToggles++;
    if (checkAux && !rst) check(usbClk === auxHist[2], "aux copy");
    if (followFast) check(pllClk === fastLast, "fast substitute");
    pllLast = pllClk;
    fastLast = fastClk;
    slowLast = slowClk;
    auxIn <= 1'($random(seed));
  end

  // One multiplier and divider setting, toggle count against the model;
  // settings land at the next toggle, and the window opens and closes
  // on the first rising edge after a pin change so both ends match
  task automatic measure(input int i, input int f, input int n);
    int e0, e1, t0, c, expv;
    intF = 7'(i);
    fracF = 2'(f);
    divSel = 6'(n);
    t0 = pllToggles;
    c = 0;
    while (pllToggles == t0 && c < 3000) begin
      @(negedge sys_clk);
      c++;
    end
    repeat (800) @(negedge sys_clk);
    e1 = edges;
    while (edges == e1) @(posedge sys_clk);
    e0 = edges;
    t0 = pllToggles;
    repeat (4000) @(posedge sys_clk);
    e1 = edges;
    while (edges == e1) @(posedge sys_clk);
    e0 = edges - e0;
    t0 = pllToggles - t0;
    @(negedge sys_clk);
    if (i == 0) expv = e0 / (n + 1);
    else expv = e0 * (4 * i + f) / (8 * (n + 1));
    check(t0 >= expv - 2 && t0 <= expv + 2, "toggle count");
    $display("Test mult %0d.%0d div %0d done", i, f, n);
  endtask

  // Main sequence
  initial begin
    int i, f, n, c, e, t, expv;
    seed = 34558;
    rst = 1'b1;
    {crystalMode, run, checkAux, followFast} = 4'h0;
    halfCycles = 8'h28;
    intF = 7'h00;
    fracF = 2'h0;
    divSel = 6'h00;
    {nMismatch, samplesChecked, pllToggles, fastToggles, slowToggles} = 0;
    repeat (2) @(negedge sys_clk);
    check(pllClk === 1'b0 && failInd === 1'b0 && oeN === 1'b1, "reset");
    rst = 1'b0;
    run = 1'b1;
    checkAux = 1'b1;
    cycles = 0;
    fastToggles = 0;
    slowToggles = 0;
    for (n = 0; n < 4; n++) measure(0, 0, n);
    // Multipliers kept small so raw edges fit the allowed rate
    repeat (6) begin
      i = 1 + (($random(seed) & 32'h7FFF) % 31);
      f = $random(seed) & 3;
      n = $random(seed) & 3;
      measure(i, f, n);
    end
    // Slow reference so the top multiplier stays below one edge a cycle
    halfCycles = 8'hFF;
    measure(127, 0, 63);
    halfCycles = 8'h28;
    expv = cycles * FAST_STEP / SYS_CLK_KHZ;
    check(fastToggles >= expv - 2 && fastToggles <= expv + 2, "fast");
    expv = cycles * SLOW_STEP / SYS_CLK_KHZ;
    check(slowToggles >= expv - 2 && slowToggles <= expv + 2, "slow");
    $display("Test internal clocks done");
    crystalMode = 1'b1;
    e = edges;
    c = 0;
    while (edges == e && c < 200) begin
      @(negedge sys_clk);
      c++;
    end
    repeat (10) @(negedge sys_clk);
    check(oeN === 1'b0 && oscOutPin === ~oscInPin, "crystal drive");
    crystalMode = 1'b0;
    repeat (2) @(negedge sys_clk);
    check(oeN === 1'b1, "single-ended release");
    $display("Test crystal done");
    intF = 7'h00;
    divSel = 6'h00;
    repeat (800) @(negedge sys_clk);
    e = edges;
    c = 0;
    while (edges == e && c < 200) begin
      @(negedge sys_clk);
      c++;
    end
    run = 1'b0;
    repeat (10) @(negedge sys_clk);
    t = pllToggles;
    repeat (1000) @(negedge sys_clk);
    check(pllToggles == t && failInd === 1'b0, "no aux path");
    c = 1000;
    while (failInd !== 1'b1 && c < 2000) begin
      @(negedge sys_clk);
      c++;
    end
    expv = MISS_TICKS * SYS_CLK_KHZ / FAST_STEP;
    check(c >= expv - 60 && c <= expv + 20, "fail delay");
    repeat (2) @(negedge sys_clk);
    followFast = 1'b1;
    repeat (200) @(negedge sys_clk);
    followFast = 1'b0;
    check(failInd === 1'b1, "fail sticky");
    $display("Test missing clock done");
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    check(failInd === 1'b0 && pllClk === 1'b0, "second reset");
    rst = 1'b0;
    run = 1'b1;
    measure(3, 2, 1);
    close_out;
  end

  // Watchdog
  initial begin
    repeat (100000) @(posedge sys_clk);
    nMismatch++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    close_out;
  end
endmodule
